/* File: core/cswrd_top.sv */
// command-mode input word block: status flags, positions and snapshot read port
`timescale 1ns/10ps
`default_nettype none
module cswrd_top
  import cswrd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CFG_MODE,
  input wire logic INT_FAULT,
  input wire logic CFG_VALID,
  input wire logic CMD_INVALID,
  input wire logic CMD_BIT,
  input wire logic CLR_ERRORS,
  input wire logic PRESET,
  input wire logic DRV_ENABLED,
  input wire logic ENABLE_REQ,
  input wire logic RESYNC_ON_ENABLE,
  input wire logic DISABLE_REQ,
  input wire logic CFG_MODE_REQ,
  input wire logic MOVE_START,
  input wire logic [2:0] MOVE_KIND,
  input wire logic MOVE_REV,
  input wire logic MOVE_END,
  input wire logic MOVE_OK,
  input wire logic ACCEL_PHASE,
  input wire logic DECEL_PHASE,
  input wire logic HOLD_DONE,
  input wire logic MOTOR_MOVING,
  input wire logic MOTOR_REV,
  input wire logic ESTOP,
  input wire logic LIMIT_FWD,
  input wire logic LIMIT_REV,
  input wire logic ENC_ERR_PWRUP,
  input wire logic STALL_STOPPED,
  input wire logic [31:0] POS_ERR_LIMIT,
  input wire logic JOG_BAD,
  input wire logic JOG_GOOD,
  input wire logic LINK_RESTORED,
  input wire logic [31:0] CMD_POS,
  input wire logic [31:0] MEAS_POS,
  input wire logic [31:0] CAPT_POS,
  input wire logic [15:0] PEAK_CUR_X100,
  input wire logic [15:0] SPEED_CPMS,
  input wire logic NET_UPDATE,
  input wire logic RD_EN,
  input wire logic [3:0] RD_ADDR,
  output logic [15:0] RD_DATA,
  output logic RD_VALID
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // helpers
  function automatic logic [32:0] pos_gap(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? 33'(-d) : d;
  endfunction

  function automatic logic [15:0] signed_mag(input logic [15:0] mag, input logic neg);
    return neg ? 16'(-mag) : mag;
  endfunction

  // ==========================================================
  // state
  typedef struct packed {
    csw_run_type run;
    csw_move_type kind;
    logic rev;
    logic cmd_flt;
    logic in_flt;
    logic untrusted;
    logic move_done;
    logic home_done;
    logic trip;
    logic ack;
    logic inv_jog;
    logic link_lost;
  } cswrd_state_type;

  cswrd_state_type st;
  cswrd_state_type next_st;

  logic [32:0] gap;
  logic big_gap;
  logic over_limit;
  logic limit_any;
  logic jog_into_limit;
  logic home_wrong_limit;
  logic clean_end;
  logic [15:0] motion_word;
  logic [15:0] drive_word;
  logic decreasing;
  logic [CSW_WORDS*16-1:0] snap;

  assign gap = pos_gap(CMD_POS, MEAS_POS);
  assign big_gap = gap > CSW_RESYNC_GAP;
  assign over_limit = gap > {1'b0, POS_ERR_LIMIT};
  assign limit_any = LIMIT_FWD | LIMIT_REV;
  assign jog_into_limit = MOVE_START && csw_move_type'(MOVE_KIND) == CSW_MV_JOG
                          && (MOVE_REV ? LIMIT_REV : LIMIT_FWD);
  // direction latched at start: the live input may already carry the next command
  assign home_wrong_limit = st.run == CSW_RUN_HOME && (st.rev ? LIMIT_FWD : LIMIT_REV);
  assign clean_end = MOVE_END && MOVE_OK && st.run == CSW_RUN_MOVE
                     && (st.kind == CSW_MV_ABS || st.kind == CSW_MV_REL || st.kind == CSW_MV_REG);
  assign decreasing = MOTOR_MOVING && MOTOR_REV;

  // ==========================================================
  // next state; in every sticky flag the set term wins over the clear
  always_comb begin
    next_st = st;
    // move activity tracking
    if (MOVE_START) begin
      next_st.kind = csw_move_type'(MOVE_KIND);
      next_st.rev = MOVE_REV;
      unique case (csw_move_type'(MOVE_KIND))
        CSW_MV_HOME: next_st.run = CSW_RUN_HOME;
        CSW_MV_FOLLOW: next_st.run = CSW_RUN_FOLLOW;
        default: next_st.run = CSW_RUN_MOVE;
      endcase
    end else if (MOVE_END) begin
      next_st.run = CSW_RUN_IDLE;
    end
    // command fault
    if (CMD_INVALID || (MOVE_START && !DRV_ENABLED) || (DISABLE_REQ && MOTOR_MOVING)
        || (CFG_MODE_REQ && DRV_ENABLED) || (ENABLE_REQ && big_gap && !RESYNC_ON_ENABLE)) begin
      next_st.cmd_flt = 1'b1;
    end else if (CLR_ERRORS) begin
      next_st.cmd_flt = 1'b0;
    end
    // input fault
    if (ESTOP || (limit_any && (st.run == CSW_RUN_MOVE || st.run == CSW_RUN_FOLLOW))
        || jog_into_limit || home_wrong_limit) begin
      next_st.in_flt = 1'b1;
    end else if (CLR_ERRORS) begin
      next_st.in_flt = 1'b0;
    end
    // position untrusted: error clear leaves it alone, preset drops it
    if (ENC_ERR_PWRUP || (ENABLE_REQ && big_gap)
        || (STALL_STOPPED && over_limit)) begin
      next_st.untrusted = 1'b1;
    end else if (PRESET) begin
      next_st.untrusted = 1'b0;
    end
    // move done; jog and homing ends excluded by clean_end
    if (clean_end) begin
      next_st.move_done = 1'b1;
    end else if (MOVE_START || PRESET || CLR_ERRORS) begin
      next_st.move_done = 1'b0;
    end
    // homing done
    if (MOVE_END && MOVE_OK && st.run == CSW_RUN_HOME) begin
      next_st.home_done = 1'b1;
    end else if (MOVE_START || (MOVE_END && st.run == CSW_RUN_HOME)) begin
      next_st.home_done = 1'b0;
    end
    // following error trip
    if (over_limit) begin
      next_st.trip = 1'b1;
    end else if (CLR_ERRORS) begin
      next_st.trip = 1'b0;
    end
    // acknowledge held until the host drops its command bit
    if (PRESET || CLR_ERRORS) begin
      next_st.ack = 1'b1;
    end else if (!CMD_BIT) begin
      next_st.ack = 1'b0;
    end
    if (JOG_BAD) begin
      next_st.inv_jog = 1'b1;
    end else if (JOG_GOOD || CLR_ERRORS) begin
      next_st.inv_jog = 1'b0;
    end
    if (LINK_RESTORED) begin
      next_st.link_lost = 1'b1;
    end else if (CLR_ERRORS) begin
      next_st.link_lost = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{run: CSW_RUN_IDLE, kind: CSW_MV_ABS, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // word assembly
  always_comb begin
    motion_word = CSW_WORD_RESET;
    motion_word[CSW_B_MODE] = CFG_MODE;
    motion_word[CSW_B_HEALTH] = !INT_FAULT;
    motion_word[CSW_B_SETUP_FLT] = !CFG_VALID;
    motion_word[CSW_B_CMD_FLT] = st.cmd_flt;
    motion_word[CSW_B_IN_FLT] = st.in_flt;
    motion_word[CSW_B_UNTRUSTED] = st.untrusted;
    motion_word[CSW_B_MOVE_DONE] = st.move_done;
    motion_word[CSW_B_DECEL] = DECEL_PHASE && st.run != CSW_RUN_IDLE;
    motion_word[CSW_B_ACCEL] = ACCEL_PHASE && st.run != CSW_RUN_IDLE;
    motion_word[CSW_B_HOME_DONE] = st.home_done;
    motion_word[CSW_B_HALTED] = st.run == CSW_RUN_FOLLOW ? 1'b0 : !MOTOR_MOVING;
    motion_word[CSW_B_PAUSED] = HOLD_DONE;
    motion_word[CSW_B_REV] = MOTOR_MOVING && MOTOR_REV;
    motion_word[CSW_B_FWD] = MOTOR_MOVING && !MOTOR_REV;
    drive_word = CSW_WORD_RESET;
    drive_word[CSW_B_POWER_ON] = DRV_ENABLED;
    drive_word[CSW_B_FOLLOW_TRIP] = st.trip;
    drive_word[CSW_B_CMD_ACK] = st.ack;
    drive_word[CSW_B_INV_JOG] = st.inv_jog;
    drive_word[CSW_B_LINK_LOST] = st.link_lost;
  end

  // low half of each position in the lower-numbered word
  assign snap = {signed_mag(SPEED_CPMS, decreasing),
                 signed_mag(PEAK_CUR_X100, decreasing),
                 CAPT_POS, MEAS_POS, CMD_POS, drive_word, motion_word};

  cswrd_words u_words (
    .clk(MCLK),
    .rst_n(rst_n),
    .wr_en(NET_UPDATE),
    .wr_data(snap),
    .rd_en(RD_EN),
    .rd_addr(RD_ADDR),
    .rd_data(RD_DATA),
    .rd_valid(RD_VALID)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  cmd_flt_set_a: assert property (CMD_INVALID |=> st.cmd_flt) else $error("command fault not set");
  flt_hold_a: assert property (st.in_flt && !CLR_ERRORS |=> st.in_flt) else $error("input fault dropped");
  estop_flt_a: assert property (ESTOP |=> motion_word[CSW_B_IN_FLT]) else $error("estop not flagged");
  untrusted_keep_a: assert property (st.untrusted && CLR_ERRORS && !PRESET |=> st.untrusted)
    else $error("untrusted cleared by error clear");
  reserved_zero_a: assert property (motion_word[9:8] == 2'b00) else $error("reserved bits set");
  jog_no_done_a: assert property (st.run == CSW_RUN_MOVE && st.kind == CSW_MV_JOG && MOVE_END && !st.move_done
    |=> !st.move_done) else $error("jog end set move done");
  follow_halt_a: assert property (st.run == CSW_RUN_FOLLOW |-> !motion_word[CSW_B_HALTED])
    else $error("halted during follower move");
  ack_drop_a: assert property (st.ack && !CMD_BIT && !PRESET && !CLR_ERRORS |=> !st.ack)
    else $error("ack not dropped");
  snap_read_a: assert property (NET_UPDATE ##1 (RD_EN && RD_ADDR == CSW_OFS_MOTION && !NET_UPDATE)
    |=> RD_DATA == $past(motion_word, 2)) else $error("snapshot mismatch");
  neg_speed_a: assert property (decreasing && SPEED_CPMS != 16'h0000 |-> snap[159] || SPEED_CPMS[15])
    else $error("speed not negative");

  // ==========================================================
  // sticky fault flags
  cmd_hold_a: assert property (st.cmd_flt && !CLR_ERRORS |=> st.cmd_flt)
    else $error("command fault dropped");
  cmd_clear_a: assert property (CLR_ERRORS && !CMD_INVALID && !MOVE_START && !DISABLE_REQ
    && !CFG_MODE_REQ && !ENABLE_REQ |=> !st.cmd_flt) else $error("command fault not cleared");
  in_clear_a: assert property (CLR_ERRORS && !ESTOP && !limit_any && !jog_into_limit |=> !st.in_flt)
    else $error("input fault not cleared");
  jog_limit_a: assert property (jog_into_limit |=> st.in_flt)
    else $error("jog into limit not flagged");
  resync_gate_a: assert property (ENABLE_REQ && big_gap && !RESYNC_ON_ENABLE |=> st.cmd_flt)
    else $error("refused enable not flagged");
  enable_gap_a: assert property (ENABLE_REQ && big_gap |=> st.untrusted)
    else $error("enable gap not flagged");
  stall_gap_a: assert property (STALL_STOPPED && over_limit |=> st.untrusted)
    else $error("stall gap not flagged");
  trip_set_a: assert property (over_limit |=> st.trip)
    else $error("following trip not set");

  // ==========================================================
  // move progress flags
  done_set_a: assert property (clean_end |=> st.move_done)
    else $error("move done not set");
  done_clear_a: assert property ((MOVE_START || PRESET || CLR_ERRORS) && !clean_end |=> !st.move_done)
    else $error("move done not cleared");
  home_no_done_a: assert property (MOVE_END && st.run == CSW_RUN_HOME && !st.move_done |=> !st.move_done)
    else $error("homing end set move done");
  home_set_a: assert property (MOVE_END && MOVE_OK && st.run == CSW_RUN_HOME |=> st.home_done)
    else $error("homing done not set");
  idle_phase_a: assert property (st.run == CSW_RUN_IDLE
    |-> !motion_word[CSW_B_ACCEL] && !motion_word[CSW_B_DECEL]) else $error("phase flag while idle");
  halt_still_a: assert property (st.run != CSW_RUN_FOLLOW && !MOTOR_MOVING |-> motion_word[CSW_B_HALTED])
    else $error("halted flag missing");

  // ==========================================================
  // acknowledge, drive flags and read port
  ack_set_a: assert property (PRESET || CLR_ERRORS |=> st.ack)
    else $error("acknowledge not set");
  link_clear_a: assert property (CLR_ERRORS && !LINK_RESTORED |=> !st.link_lost)
    else $error("link lost not cleared");
  jog_clear_a: assert property (CLR_ERRORS && !JOG_BAD |=> !st.inv_jog)
    else $error("jog change not cleared");
  rd_valid_a: assert property (RD_EN |=> RD_VALID)
    else $error("read answer missing");
  reserved_read_a: assert property (RD_VALID && $past(RD_ADDR) == CSW_OFS_MOTION |-> RD_DATA[9:8] == 2'b00)
    else $error("reserved bits read set");
  neg_cur_a: assert property (decreasing && PEAK_CUR_X100 != 16'h0000 |-> snap[143] || PEAK_CUR_X100[15])
    else $error("current not negative");

  done_c: cover property (clean_end ##1 st.move_done);
  home_c: cover property (MOVE_END && MOVE_OK && st.run == CSW_RUN_HOME);
  clear_c: cover property (st.cmd_flt ##1 CLR_ERRORS ##1 !st.cmd_flt);
  read_c: cover property (NET_UPDATE ##1 RD_EN ##1 RD_VALID);
  resync_c: cover property (ENABLE_REQ && big_gap && RESYNC_ON_ENABLE);
endmodule
`default_nettype wire

/* File: core/cswrd_pkg.sv */
// constants and types shared by the command-mode input word block
package cswrd_pkg;
  // ==========================================================
  // word indices of the input data block
  localparam logic [3:0] CSW_OFS_MOTION = 4'h0;
  localparam logic [3:0] CSW_OFS_DRIVE = 4'h1;
  localparam logic [3:0] CSW_OFS_CMD_POS = 4'h2;
  localparam logic [3:0] CSW_OFS_MEAS_POS = 4'h4;
  localparam logic [3:0] CSW_OFS_CAPT_POS = 4'h6;
  localparam logic [3:0] CSW_OFS_PEAK_CUR = 4'h8;
  localparam logic [3:0] CSW_OFS_SPEED = 4'h9;
  localparam int CSW_WORDS = 10;
  // ==========================================================
  // motion status word bit positions
  localparam int CSW_B_MODE = 15;
  localparam int CSW_B_HEALTH = 14;
  localparam int CSW_B_SETUP_FLT = 13;
  localparam int CSW_B_CMD_FLT = 12;
  localparam int CSW_B_IN_FLT = 11;
  localparam int CSW_B_UNTRUSTED = 10;
  localparam int CSW_B_MOVE_DONE = 7;
  localparam int CSW_B_DECEL = 6;
  localparam int CSW_B_ACCEL = 5;
  localparam int CSW_B_HOME_DONE = 4;
  localparam int CSW_B_HALTED = 3;
  localparam int CSW_B_PAUSED = 2;
  localparam int CSW_B_REV = 1;
  localparam int CSW_B_FWD = 0;
  // ==========================================================
  // drive status word bit positions
  localparam int CSW_B_POWER_ON = 15;
  localparam int CSW_B_FOLLOW_TRIP = 14;
  localparam int CSW_B_CMD_ACK = 13;
  localparam int CSW_B_INV_JOG = 9;
  localparam int CSW_B_LINK_LOST = 6;
  // ==========================================================
  // limits and reset values
  localparam logic [32:0] CSW_RESYNC_GAP = 33'h0_0000_1000;
  localparam logic [15:0] CSW_WORD_RESET = 16'h0000;
  // ==========================================================
  // move kinds reported with a move start
  typedef enum logic [2:0] {
    CSW_MV_ABS = 3'b000,
    CSW_MV_REL = 3'b001,
    CSW_MV_REG = 3'b010,
    CSW_MV_JOG = 3'b011,
    CSW_MV_HOME = 3'b100,
    CSW_MV_FOLLOW = 3'b101
  } csw_move_type;
  // activity of the present move
  typedef enum logic [1:0] {
    CSW_RUN_IDLE = 2'b00,
    CSW_RUN_MOVE = 2'b01,
    CSW_RUN_FOLLOW = 2'b10,
    CSW_RUN_HOME = 2'b11
  } csw_run_type;
endpackage

/* File: core/cswrd_words.sv */
// ten-word snapshot store with registered read port
`timescale 1ns/10ps
`default_nettype none
module cswrd_words
  import cswrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [CSW_WORDS*16-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid
);
  logic [15:0] mem [CSW_WORDS];

  // ==========================================================
  // whole block written at once so every update is coherent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CSW_WORDS; i++) begin
        mem[i] <= CSW_WORD_RESET;
      end
      rd_data <= CSW_WORD_RESET;
      rd_valid <= 1'b0;
    end else begin
      if (wr_en) begin
        for (int i = 0; i < CSW_WORDS; i++) begin
          mem[i] <= wr_data[i*16 +: 16];
        end
      end
      rd_valid <= rd_en;
      if (rd_en) begin
        // unmapped indices read as zero
        rd_data <= (int'(rd_addr) < CSW_WORDS) ? mem[rd_addr] : CSW_WORD_RESET;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/cswrd_host.sv */
// host model that snapshots and polls the ten input words
`timescale 1ns/10ps
`default_nettype none
module cswrd_host (
  input wire logic MCLK,
  output logic NET_UPDATE,
  output logic RD_EN,
  output logic [3:0] RD_ADDR,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_VALID
);
  // ==========================================================
  // poll: one snapshot, then back-to-back reads of words 0..10
  initial begin
    NET_UPDATE = 1'b0;
    RD_EN = 1'b0;
    RD_ADDR = 4'hF;
  end
  task automatic poll(output logic [175:0] w, output bit ok);
    ok = 1'b1;
    w = '0;
    @(negedge MCLK);
    NET_UPDATE = 1'b1;
    @(negedge MCLK);
    NET_UPDATE = 1'b0;
    RD_EN = 1'b1;
    RD_ADDR = 4'h0;
    for (int i = 0; i < 11; i++) begin
      @(negedge MCLK);
      // answer stands one cycle only, so it is taken here or lost
      if (RD_VALID !== 1'b1) ok = 1'b0;
      w[16*i +: 16] = RD_DATA;
      if (i < 10) RD_ADDR = RD_ADDR + 4'h1;
      else RD_EN = 1'b0;
    end
    // idle address keeps moving so a stale index cannot pass
    RD_ADDR = ~RD_ADDR;
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the command-mode input word block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cswrd_pkg::*;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic CFG_MODE, INT_FAULT, CFG_VALID, CMD_BIT, DRV_ENABLED, RESYNC_ON_ENABLE, MOVE_REV, MOVE_OK;
  logic ACCEL_PHASE, DECEL_PHASE, HOLD_DONE, MOTOR_MOVING, MOTOR_REV, ESTOP, LIMIT_FWD, LIMIT_REV;
  logic [2:0] MOVE_KIND;
  logic [31:0] POS_ERR_LIMIT, CMD_POS, MEAS_POS, CAPT_POS, rv;
  logic [15:0] PEAK_CUR_X100, SPEED_CPMS;
  wire logic NET_UPDATE, RD_EN, RD_VALID;
  wire logic [3:0] RD_ADDR;
  wire logic [15:0] RD_DATA;
  logic [12:0] pv = '0;
  wire logic CMD_INVALID, CLR_ERRORS, PRESET, ENABLE_REQ, DISABLE_REQ, CFG_MODE_REQ, MOVE_START;
  wire logic MOVE_END, ENC_ERR_PWRUP, STALL_STOPPED, JOG_BAD, JOG_GOOD, LINK_RESTORED;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32;
  logic e_cf, e_if, e_un, e_dn, e_hm, e_tr, e_ak, e_jg, e_ll, act, fol;
  logic [2:0] mk;
  assign {LINK_RESTORED, JOG_GOOD, JOG_BAD, STALL_STOPPED, ENC_ERR_PWRUP, MOVE_END, MOVE_START,
          CFG_MODE_REQ, DISABLE_REQ, ENABLE_REQ, PRESET, CLR_ERRORS, CMD_INVALID} = pv;
  cswrd_top cswrd_top_i (.*);
  cswrd_host cswrd_host_i (.*);
  always #5 MCLK = ~MCLK;
  // ==========================================================
  // reference model and helpers
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic longint gap();
    gap = longint'($signed(CMD_POS)) - longint'($signed(MEAS_POS));
    if (gap < 0) gap = -gap;
  endfunction
  function automatic logic [15:0] sg(input logic [15:0] v);
    sg = (MOTOR_MOVING && MOTOR_REV) ? 16'h0000 - v : v;
  endfunction
  // one-cycle event pulse; sticky flags follow the model
  task automatic ev(input int k);
    @(negedge MCLK);
    pv[k] = 1'b1;
    case (k)
      0: e_cf = 1'b1;
      1: begin
        {e_cf, e_if, e_dn, e_tr, e_jg, e_ll} = '0;
        e_ak = CMD_BIT;
      end
      2: begin
        {e_un, e_dn} = '0;
        e_ak = CMD_BIT;
      end
      3: if (gap() > 4096) begin
        e_un = 1'b1;
        if (!RESYNC_ON_ENABLE) e_cf = 1'b1;
      end
      4: if (MOTOR_MOVING) e_cf = 1'b1;
      5: if (DRV_ENABLED) e_cf = 1'b1;
      8: e_un = 1'b1;
      9: if (gap() > POS_ERR_LIMIT) e_un = 1'b1;
      10: e_jg = 1'b1;
      11: e_jg = 1'b0;
      12: e_ll = 1'b1;
      default: ;
    endcase
    @(negedge MCLK);
    pv = '0;
  endtask
  task automatic mv(input logic [2:0] k, input logic r);
    MOVE_KIND = k;
    MOVE_REV = r;
    ev(6);
    mk = k;
    act = 1'b1;
    fol = (k == CSW_MV_FOLLOW);
    {e_dn, e_hm} = '0;
    if (!DRV_ENABLED) e_cf = 1'b1;
    if (k == CSW_MV_JOG && (r ? LIMIT_REV : LIMIT_FWD)) e_if = 1'b1;
  endtask
  task automatic fin(input logic ok);
    MOVE_OK = ok;
    ev(7);
    if (ok && mk inside {CSW_MV_ABS, CSW_MV_REL, CSW_MV_REG}) e_dn = 1'b1;
    if (mk == CSW_MV_HOME) e_hm = ok;
    {act, fol} = '0;
  endtask
  // snapshot, read all words and compare with the model
  task automatic check(input string s);
    logic [175:0] got, ex;
    logic [15:0] m, d;
    bit ok;
    if (gap() > POS_ERR_LIMIT) e_tr = 1'b1;
    m = {CFG_MODE, !INT_FAULT, !CFG_VALID, e_cf, e_if, e_un, 2'b00, e_dn, DECEL_PHASE && act,
         ACCEL_PHASE && act, e_hm, !MOTOR_MOVING && !fol, HOLD_DONE, MOTOR_MOVING && MOTOR_REV,
         MOTOR_MOVING && !MOTOR_REV};
    d = {DRV_ENABLED, e_tr, e_ak, 3'b000, e_jg, 2'b00, e_ll, 6'h00};
    ex = {16'h0000, sg(SPEED_CPMS), sg(PEAK_CUR_X100), CAPT_POS, MEAS_POS, CMD_POS, d, m};
    cswrd_host_i.poll(got, ok);
    for (int i = 0; i < 11; i++) begin
      n_tests++;
      if (got[16*i +: 16] !== ex[16*i +: 16]) begin
        error_cnt++;
        $display("Error at %0t: %s word %0d got %h want %h", $time, s, i, got[16*i +: 16], ex[16*i +: 16]);
      end
    end
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s read answer missing", $time, s);
      complete_run();
    end
    $display("test %s finished", s);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {CFG_MODE, INT_FAULT, DRV_ENABLED, RESYNC_ON_ENABLE, MOVE_REV, MOVE_OK, MOVE_KIND} = '0;
    {ACCEL_PHASE, DECEL_PHASE, HOLD_DONE, MOTOR_MOVING, MOTOR_REV, ESTOP, LIMIT_FWD, LIMIT_REV} = '0;
    {e_cf, e_if, e_un, e_dn, e_hm, e_tr, e_ak, e_jg, e_ll, act, fol, mk} = '0;
    {CMD_POS, MEAS_POS, CAPT_POS, PEAK_CUR_X100, SPEED_CPMS, rv} = '0;
    {CFG_VALID, CMD_BIT} = 2'b11;
    POS_ERR_LIMIT = 32'h0001_0000;
    repeat (20) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (4) @(negedge MCLK);
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      {CFG_MODE, INT_FAULT, CFG_VALID, DRV_ENABLED, MOTOR_MOVING, MOTOR_REV} = rv[5:0];
      PEAK_CUR_X100 = {1'b0, rv[30:16]};
      SPEED_CPMS = {1'b0, rv[14:0]};
      CMD_POS = $random(seed);
      MEAS_POS = CMD_POS;
      CAPT_POS = $random(seed);
      check("levels");
    end
    {CFG_MODE, INT_FAULT, MOTOR_MOVING, MOTOR_REV} = '0;
    {CFG_VALID, DRV_ENABLED} = 2'b11;
    for (int k = 0; k < 7; k++) begin
      DRV_ENABLED = (k != 1);
      MOTOR_MOVING = (k == 2);
      RESYNC_ON_ENABLE = (k == 6);
      // 4097 apart must refuse the enable, exactly 4096 must not; resync waives it
      MEAS_POS = (k == 4 || k == 6) ? CMD_POS + 32'd4097 : CMD_POS - 32'd4096;
      case (k)
        0: ev(0);
        1: mv(CSW_MV_ABS, 1'b0);
        2: ev(4);
        3: ev(5);
        default: ev(3);
      endcase
      check("command fault");
      if (act) fin(1'b0);
      MEAS_POS = CMD_POS;
      MOTOR_MOVING = 1'b0;
      DRV_ENABLED = 1'b1;
      ev(1);
      check("fault clear");
    end
    RESYNC_ON_ENABLE = 1'b0;
    ev(2);
    check("preset");
    CMD_BIT = 1'b0;
    e_ak = 1'b0;
    check("ack drop");
    CMD_BIT = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ESTOP = (k == 0);
      LIMIT_REV = (k == 2);
      if (k > 0) mv(k == 1 ? CSW_MV_ABS : k == 2 ? CSW_MV_JOG : CSW_MV_HOME, k == 2);
      LIMIT_FWD = (k == 1);
      if (k == 3) LIMIT_REV = 1'b1;
      e_if = 1'b1;
      check("input fault");
      {ESTOP, LIMIT_FWD, LIMIT_REV} = '0;
      check("input fault held");
      if (act) fin(1'b0);
      ev(1);
      check("input clear");
    end
    for (int k = 0; k < 6; k++) begin
      mv(k[2:0], k[0]);
      {ACCEL_PHASE, HOLD_DONE} = 2'b11;
      check("accelerate");
      {ACCEL_PHASE, DECEL_PHASE, MOTOR_MOVING, MOTOR_REV} = {3'b011, k[0]};
      check("decelerate");
      {DECEL_PHASE, HOLD_DONE, MOTOR_MOVING} = '0;
      fin(1'b1);
      check("move end");
    end
    mv(CSW_MV_ABS, 1'b0);
    fin(1'b0);
    check("stopped");
    POS_ERR_LIMIT = 32'h0000_0100;
    MEAS_POS = CMD_POS + 32'h0000_0100;
    ev(8);
    check("gap at limit");
    ev(2);
    MEAS_POS = CMD_POS - 32'h0000_0101;
    ev(9);
    ev(10);
    ev(12);
    check("stall");
    ev(11);
    MEAS_POS = CMD_POS;
    ev(1);
    check("drive clear");
    complete_run();
  end
endmodule
`default_nettype wire
